//--- rtl/flash_host.sv
// module: host controller issuing flash command sequences from software orders
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - reset accepted mid autoselect; host writes reset to leave autoselect
// - on timing limit flag host writes reset; device reads array; here the host only sets the timeout flag and software orders the reset
// - program is two unlocks, set-up, then address and data
// - two unlocks then 20h enters bypass mode
// - bypass program is A0h then address and data, repeatable
// - bypass exit is 90h then 00h at any address
// - chip erase is six cycles: unlocks, set-up, unlocks, erase command
// - write cycle is ce and we low with oe high
module flash_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  input wire logic flash_ready_busy
);
  bus_cycle_if bc ();
  flash_host_pkg::host_state_t state_ff;
  logic [3:0] op_ff;
  logic [19:0] taddr_ff;
  logic [15:0] tdata_ff;
  logic [15:0] rdata_ff;
  logic [2:0] step_ff;
  logic [2:0] nsteps_ff;
  logic start_ff;
  logic bypass_ff;
  logic autosel_ff;
  logic timeout_ff;
  logic [31:0] rdata_out_ff;
  logic hwreset_ff;
  logic [19:0] cyc_addr;
  logic [15:0] cyc_data;
  logic cyc_write;
  logic [2:0] op_steps;
  // command cycle table: steps of the selected sequence
  always_comb begin
    cyc_addr = flash_host_pkg::UNLOCK_ADDR1;
    cyc_data = {8'h00, flash_host_pkg::CMD_UNLOCK1};
    cyc_write = 1'b1;
    case (op_ff)
      flash_host_pkg::OP_READ: begin
        cyc_addr = taddr_ff;
        cyc_write = 1'b0;
      end
      flash_host_pkg::OP_RESET: begin
        cyc_addr = taddr_ff;
        cyc_data = {8'h00, flash_host_pkg::CMD_RESET};
      end
      flash_host_pkg::OP_BYP_PROGRAM: begin
        cyc_addr = taddr_ff;
        cyc_data = (step_ff == 3'd0) ? {8'h00, flash_host_pkg::CMD_PROGRAM} : tdata_ff;
      end
      flash_host_pkg::OP_BYP_EXIT: begin
        cyc_addr = taddr_ff;
        cyc_data = (step_ff == 3'd0) ? {8'h00, flash_host_pkg::CMD_BYPASS_EXIT1}
                                     : {8'h00, flash_host_pkg::CMD_BYPASS_EXIT2};
      end
      default: begin
        if (step_ff == 3'd1 || step_ff == 3'd4) begin
          cyc_addr = flash_host_pkg::UNLOCK_ADDR2;
          cyc_data = {8'h00, flash_host_pkg::CMD_UNLOCK2};
        end else if (step_ff == 3'd3) begin
          cyc_data = {8'h00, flash_host_pkg::CMD_UNLOCK1};
        end else if (step_ff == 3'd5) begin
          cyc_data = {8'h00, flash_host_pkg::CMD_CHIP_ERASE};
        end else if (step_ff == 3'd2) begin
          case (op_ff)
            flash_host_pkg::OP_AUTOSEL: cyc_data = {8'h00, flash_host_pkg::CMD_AUTOSEL};
            flash_host_pkg::OP_PROGRAM: cyc_data = {8'h00, flash_host_pkg::CMD_PROGRAM};
            flash_host_pkg::OP_BYP_ENTER: cyc_data = {8'h00, flash_host_pkg::CMD_BYPASS};
            default: cyc_data = {8'h00, flash_host_pkg::CMD_ERASE_SETUP};
          endcase
        end else if (op_ff == flash_host_pkg::OP_PROGRAM && step_ff == 3'd3) begin
          cyc_addr = taddr_ff;
        end
        if (op_ff == flash_host_pkg::OP_PROGRAM && step_ff == 3'd3) begin
          cyc_addr = taddr_ff;
          cyc_data = tdata_ff;
        end
      end
    endcase
    // status reads at the target address while the embedded algorithm runs
    if (state_ff == flash_host_pkg::S_POLL) begin
      cyc_addr = taddr_ff;
      cyc_write = 1'b0;
    end
  end
  always_comb begin
    case (op_ff)
      flash_host_pkg::OP_READ: op_steps = 3'd1;
      flash_host_pkg::OP_RESET: op_steps = 3'd1;
      flash_host_pkg::OP_AUTOSEL: op_steps = 3'd3;
      flash_host_pkg::OP_PROGRAM: op_steps = 3'd4;
      flash_host_pkg::OP_BYP_ENTER: op_steps = 3'd3;
      flash_host_pkg::OP_BYP_PROGRAM: op_steps = 3'd2;
      flash_host_pkg::OP_BYP_EXIT: op_steps = 3'd2;
      default: op_steps = 3'd6;
    endcase
  end
  assign bc.start = start_ff;
  assign bc.is_write = cyc_write;
  assign bc.addr = cyc_addr;
  assign bc.wdata = cyc_data;
  wire is_prog = (op_ff == flash_host_pkg::OP_PROGRAM) ||
                 (op_ff == flash_host_pkg::OP_BYP_PROGRAM);
  wire is_embedded = is_prog || (op_ff == flash_host_pkg::OP_CHIP_ERASE);
  wire last_step = (step_ff == nsteps_ff - 3'd1);
  wire busy = (state_ff != flash_host_pkg::S_IDLE);
  wire ctrl_wr = reg_wr && (reg_addr == flash_host_pkg::REG_CTRL) && !busy;
  // in bypass only bypass program, bypass exit or read may be issued
  wire op_legal = bypass_ff ? (reg_wdata[3:0] == flash_host_pkg::OP_BYP_PROGRAM ||
                               reg_wdata[3:0] == flash_host_pkg::OP_BYP_EXIT ||
                               reg_wdata[3:0] == flash_host_pkg::OP_READ)
                            : (reg_wdata[3:0] != flash_host_pkg::OP_BYP_PROGRAM &&
                               reg_wdata[3:0] != flash_host_pkg::OP_BYP_EXIT &&
                               reg_wdata[3:0] <= flash_host_pkg::OP_CHIP_ERASE);
  // timing limit flag seen while flash_ready_busy is low means a failed operation
  wire poll_fail = bc.done && bc.rdata[5] == 1'b1 && flash_ready_busy == 1'b0;
  wire poll_ok = flash_ready_busy == 1'b1;
  wire [31:0] status_word = {27'h0, autosel_ff, bypass_ff, timeout_ff, !flash_ready_busy, busy};
  wire [31:0] rd_mux =
    (reg_addr == flash_host_pkg::REG_ADDR) ? {12'h000, taddr_ff} :
    (reg_addr == flash_host_pkg::REG_DATA) ? {16'h0000, rdata_ff} :
    (reg_addr == flash_host_pkg::REG_STATUS) ? status_word :
    (reg_addr == flash_host_pkg::REG_CTRL) ? {28'h000_0000, op_ff} : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (rst) rdata_out_ff <= 32'h0000_0000;
    else rdata_out_ff <= reg_rd ? rd_mux : 32'h0000_0000;
  end
  assign reg_rdata = rdata_out_ff;
  assign flash_reset_n = !hwreset_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= flash_host_pkg::S_IDLE;
      op_ff <= flash_host_pkg::OP_READ;
      taddr_ff <= 20'h0_0000;
      tdata_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      step_ff <= 3'd0;
      nsteps_ff <= 3'd1;
      start_ff <= 1'b0;
      bypass_ff <= 1'b0;
      autosel_ff <= 1'b0;
      timeout_ff <= 1'b0;
      hwreset_ff <= 1'b1;
    end else begin
      hwreset_ff <= 1'b0;
      start_ff <= 1'b0;
      if (reg_wr && reg_addr == flash_host_pkg::REG_ADDR && !busy) taddr_ff <= reg_wdata[19:0];
      if (reg_wr && reg_addr == flash_host_pkg::REG_DATA && !busy) tdata_ff <= reg_wdata[15:0];
      if (reg_wr && reg_addr == flash_host_pkg::REG_STATUS &&
          reg_wdata[flash_host_pkg::ST_TIMEOUT]) begin
        timeout_ff <= 1'b0;
      end
      case (state_ff)
        flash_host_pkg::S_IDLE: begin
          if (ctrl_wr && op_legal) begin
            op_ff <= reg_wdata[3:0];
            step_ff <= 3'd0;
            start_ff <= 1'b1;
            state_ff <= flash_host_pkg::S_CYCLE;
          end
        end
        flash_host_pkg::S_CYCLE: begin
          nsteps_ff <= op_steps;
          if (bc.done) begin
            if (!cyc_write) rdata_ff <= bc.rdata;
            if (last_step) begin
              state_ff <= is_embedded ? flash_host_pkg::S_POLL : flash_host_pkg::S_DONE;
              start_ff <= is_embedded;
              if (op_ff == flash_host_pkg::OP_AUTOSEL) autosel_ff <= 1'b1;
              if (op_ff == flash_host_pkg::OP_RESET) autosel_ff <= 1'b0;
              if (op_ff == flash_host_pkg::OP_BYP_ENTER) bypass_ff <= 1'b1;
              if (op_ff == flash_host_pkg::OP_BYP_EXIT) bypass_ff <= 1'b0;
            end else begin
              step_ff <= step_ff + 3'd1;
              start_ff <= 1'b1;
            end
          end
        end
        flash_host_pkg::S_POLL: begin
          // no commands issued while the embedded algorithm runs
          // leave only at a cycle end, else the next start meets an active pin driver
          if (bc.done) begin
            if (poll_ok || poll_fail) begin
              state_ff <= flash_host_pkg::S_DONE;
            end else begin
              start_ff <= 1'b1;
            end
          end
        end
        flash_host_pkg::S_DONE: begin
          state_ff <= flash_host_pkg::S_IDLE;
        end
        default: state_ff <= flash_host_pkg::S_IDLE;
      endcase
      // timing limit: record it, software then issues the reset order
      if (state_ff == flash_host_pkg::S_POLL && poll_fail) timeout_ff <= 1'b1;
    end
  end
  flash_pin_driver u_pins (
    .clk(clk),
    .rst(rst),
    .bc(bc.pin),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n)
  );
endmodule

//--- rtl/flash_pin_driver.sv
// module: drives one flash read or write bus cycle on the pins
`timescale 1ns/1ps
module flash_pin_driver (
  input wire logic clk,
  input wire logic rst,
  bus_cycle_if.pin bc,
  output logic [19:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  logic [4:0] cnt_ff;
  logic act_ff;
  logic wr_ff;
  logic done_ff;
  logic [15:0] rdata_ff;
  logic [19:0] addr_ff;
  logic [15:0] dout_ff;
  wire last = act_ff && (cnt_ff == 5'h00);
  assign bc.done = done_ff;
  assign bc.rdata = rdata_ff;
  assign flash_addr = addr_ff;
  assign flash_dq_out = dout_ff;
  assign flash_dq_oe = act_ff && wr_ff;
  // write: ce and we low, oe high; any other combination inhibits writing
  assign flash_ce_n = !act_ff;
  assign flash_we_n = !(act_ff && wr_ff);
  assign flash_oe_n = !(act_ff && !wr_ff);
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 5'h00;
      act_ff <= 1'b0;
      wr_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      addr_ff <= 20'h0_0000;
      dout_ff <= 16'h0000;
    end else begin
      done_ff <= last;
      if (bc.start && !act_ff) begin
        act_ff <= 1'b1;
        wr_ff <= bc.is_write;
        addr_ff <= bc.addr;
        dout_ff <= bc.wdata;
        cnt_ff <= flash_host_pkg::CYCLE_CNT;
      end else if (last) begin
        act_ff <= 1'b0;
        if (!wr_ff) rdata_ff <= flash_dq_in;
      end else if (act_ff) begin
        cnt_ff <= cnt_ff - 5'h01;
      end
    end
  end
endmodule

//--- shared/bus_cycle_if.sv
// interface: one flash bus cycle request and completion between sequencer and pin driver
`timescale 1ns/1ps
interface bus_cycle_if;
  logic start;
  logic is_write;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output start, output is_write, output addr, output wdata,
    input done, input rdata);
  modport pin (input start, input is_write, input addr, input wdata,
    output done, output rdata);
endinterface

//--- shared/flash_host_pkg.sv
// package: command codes, unlock addresses, timing counts and states for the flash host
package flash_host_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  // command data values
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
  // unlock addresses, word mode
  localparam logic [19:0] UNLOCK_ADDR1 = 20'h0_0555;
  localparam logic [19:0] UNLOCK_ADDR2 = 20'h0_02AA;
  // autoselect read offsets
  localparam logic [7:0] AS_MANUF = 8'h00;
  localparam logic [7:0] AS_DEVICE = 8'h01;
  localparam logic [7:0] AS_PROT_WORD = 8'h02;
  localparam logic [7:0] AS_PROT_BYTE = 8'h04;
  // bus cycle timing in ns, converted at 200 MHz
  localparam int CLK_PS = 5000;
  localparam int CYCLE_NS = 70;
  localparam int CYCLE_CLKS = (CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [4:0] CYCLE_CNT = 5'(CYCLE_CLKS);
  // software ops
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_RESET = 4'h1;
  localparam logic [3:0] OP_AUTOSEL = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_BYP_ENTER = 4'h4;
  localparam logic [3:0] OP_BYP_PROGRAM = 4'h5;
  localparam logic [3:0] OP_BYP_EXIT = 4'h6;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h7;
  // host register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int ST_BUSY = 0;
  localparam int ST_FLASH_BUSY = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_BYPASS = 3;
  localparam int ST_AUTOSEL = 4;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_CYCLE = 4'b0010,
    S_POLL = 4'b0100,
    S_DONE = 4'b1000
  } host_state_t;
endpackage

//--- tb/flash_device_model.sv
// device model: command state machine, small array, identification codes, busy timing
`timescale 1ns/1ps
module flash_device_model #(
  parameter logic [15:0] MANUF_CODE = 16'h003A, // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h5A17, // arbitrary value
  parameter int BUSY_CLKS = 40
) (
  input wire logic clk,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  output logic [15:0] flash_dq_in,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  output logic flash_ready_busy
);
  logic [15:0] mem [16];
  logic [15:0] wd, last, pd, rd_val;
  logic [19:0] wa;
  logic wr_low, tog, rd_on, halted, fail_next;
  int step, mode, busy, wr_count;
  wire [7:0] lo = flash_addr[7:0];
  assign rd_val = (busy > 0) ? {8'h00, ~pd[7], tog, halted, 5'h00}
    : (mode != 1) ? mem[flash_addr[3:0]] : (lo == flash_host_pkg::AS_MANUF) ? MANUF_CODE
    : (lo == flash_host_pkg::AS_DEVICE) ? DEVICE_CODE : 16'h0000;
  // released bus shows inverse of last value, so stale data never passes
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd_val : ~last;
  assign flash_ready_busy = (busy == 0);
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {wr_low, tog, rd_on, halted, fail_next, step, mode, busy, wr_count, last, pd} = '0;
  end
  task automatic cmd(input logic [19:0] a, input logic [15:0] d);
    logic u1, u2;
    logic [7:0] c;
    u1 = (a == flash_host_pkg::UNLOCK_ADDR1);
    u2 = (a == flash_host_pkg::UNLOCK_ADDR2);
    c = d[7:0];
    // a halted operation waits for the reset command
    if (busy > 0 && !(halted && c == flash_host_pkg::CMD_RESET)) return;
    if (mode == 2) begin
      if (step == 1) mem[a[3:0]] = mem[a[3:0]] & d;
      if (step == 1) pd = d;
      if (step == 1) busy = BUSY_CLKS;
      if (step == 2) mode = (c == flash_host_pkg::CMD_BYPASS_EXIT2) ? 0 : 2;
      step = (step != 0) ? 0 : (c == flash_host_pkg::CMD_PROGRAM) ? 1
        : (c == flash_host_pkg::CMD_BYPASS_EXIT1) ? 2 : 0;
    end else if (c == flash_host_pkg::CMD_RESET) begin
      mode = 0;
      step = 0;
      busy = 0;
      halted = 0;
    end else begin
      case (step)
        0: step = (u1 && c == flash_host_pkg::CMD_UNLOCK1) ? 1 : 0;
        1: step = (u2 && c == flash_host_pkg::CMD_UNLOCK2) ? 2 : 0;
        2: begin
          if (u1 && c == flash_host_pkg::CMD_AUTOSEL) mode = 1;
          if (u1 && c == flash_host_pkg::CMD_BYPASS) mode = 2;
          step = (u1 && c == flash_host_pkg::CMD_PROGRAM) ? 3
            : (u1 && c == flash_host_pkg::CMD_ERASE_SETUP) ? 4 : 0;
        end
        3: begin
          mem[a[3:0]] = mem[a[3:0]] & d;
          pd = d;
          halted = fail_next;
          fail_next = 1'b0;
          busy = BUSY_CLKS;
          step = 0;
        end
        4: step = (u1 && c == flash_host_pkg::CMD_UNLOCK1) ? 5 : 0;
        5: step = (u2 && c == flash_host_pkg::CMD_UNLOCK2) ? 6 : 0;
        default: begin
          if (u1 && c == flash_host_pkg::CMD_CHIP_ERASE) begin
            foreach (mem[i]) mem[i] = 16'hFFFF;
            pd = 16'hFFFF;
            busy = 2 * BUSY_CLKS;
          end
          step = 0;
        end
      endcase
    end
  endtask
  // falling edge sampling keeps clear of the host's own rising-edge updates
  always @(negedge clk) begin
    if (!flash_reset_n) begin
      busy = 0;
      halted = 0;
      step = 0;
      mode = 0;
    end else begin
      if (busy > 0 && !halted) busy = busy - 1;
      if (!flash_we_n && !flash_ce_n && flash_oe_n) begin
        wr_low = 1;
        wa = flash_addr;
        wd = flash_dq_out;
      end else if (wr_low) begin
        wr_low = 0;
        wr_count++;
        cmd(wa, wd);
      end
      if (!flash_oe_n && !flash_ce_n) last = rd_val;
      if (!flash_oe_n) rd_on = 1;
      else if (rd_on) begin
        rd_on = 0;
        tog = ~tog;
      end
    end
  end
endmodule

//--- tb/flash_host_monitor.sv
// checker: pin and register-port timing of the flash host
`timescale 1ns/1ps
module flash_host_monitor (
  input wire logic clk, rst, reg_wr, reg_rd, flash_dq_oe,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out, flash_dq_in,
  input wire logic flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, flash_ready_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_idle_a:
    assert property (disable iff (1'b0) rst |=> flash_ce_n && flash_we_n && flash_oe_n
      && !flash_dq_oe && !flash_reset_n) else $error("pins not idle in reset");
  write_inhibit_a:
    assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n) else $error("bad write pins");
  drive_write_a:
    assert property (!flash_we_n |-> flash_dq_oe) else $error("write without data drive");
  no_contend_a:
    assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n) else $error("read contention");
  addr_hold_a:
    assert property (!flash_we_n && $past(!flash_we_n) |-> $stable(flash_addr)
      && $stable(flash_dq_out)) else $error("address or data moved in write");
  busy_quiet_a:
    assert property (!flash_ready_busy && !flash_we_n |->
      flash_dq_out[7:0] == flash_host_pkg::CMD_RESET) else $error("write while busy");
  rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("rdata not zero");
  cycle_len_a:
    assert property ($fell(flash_ce_n) |-> !flash_ce_n [*8]) else $error("bus cycle too short");
endmodule

//--- tb/flash_host_tb.sv
// testbench: software orders through host registers against the device model
`timescale 1ns/1ps
module flash_host_tb;
  localparam logic [15:0] MANUF = 16'h003A; // arbitrary value
  localparam logic [15:0] DEVID = 16'h5A17; // arbitrary value
  typedef struct {logic [3:0] op; logic [19:0] a; logic [15:0] d; bit c; logic [15:0] e; int n;} row_t;
  logic clk, rst, reg_wr, reg_rd, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic flash_reset_n, flash_ready_busy;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  int bad_count = 0;
  int n_checks = 0;
  flash_host dut_u (.*);
  flash_device_model #(.MANUF_CODE(MANUF), .DEVICE_CODE(DEVID)) dev_u (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic run_op(input logic [3:0] op, input logic [19:0] a, input logic [15:0] d);
    logic [31:0] s;
    wr(flash_host_pkg::REG_ADDR, {12'h000, a});
    wr(flash_host_pkg::REG_DATA, {16'h0000, d});
    wr(flash_host_pkg::REG_CTRL, {28'h000_0000, op});
    s = 32'h0000_0001;
    for (int i = 0; i < 400 && s[flash_host_pkg::ST_BUSY] !== 1'b0; i++) begin
      rd(flash_host_pkg::REG_STATUS, s);
    end
    if (s[flash_host_pkg::ST_BUSY] !== 1'b0) check("busy wait", 32'h0000_0000, s);
  endtask
  initial begin
    row_t rows[20];
    logic [31:0] v;
    int n0;
    rows = '{'{4'h0, 20'h0_0003, 16'h0000, 1, 16'hFFFF, 0}, '{4'h3, 20'h0_0003, 16'h1234, 0, 0, 4},
      '{4'h0, 20'h0_0003, 16'h0000, 1, 16'h1234, 0}, '{4'h3, 20'h0_0003, 16'hFF00, 0, 0, 4},
      '{4'h0, 20'h0_0003, 16'h0000, 1, 16'h1200, 0}, '{4'h2, 20'h0_0000, 16'h0000, 0, 0, 3},
      '{4'h0, 20'h0_0100, 16'h0000, 1, MANUF, 0}, '{4'h0, 20'h0_0201, 16'h0000, 1, DEVID, 0},
      '{4'h0, 20'h0_0002, 16'h0000, 1, 16'h0000, 0}, '{4'h1, 20'h0_0777, 16'h0000, 0, 0, 1},
      '{4'h0, 20'h0_0003, 16'h0000, 1, 16'h1200, 0}, '{4'h5, 20'h0_0005, 16'h00AA, 0, 0, 0},
      '{4'h4, 20'h0_0000, 16'h0000, 0, 0, 3}, '{4'h3, 20'h0_0005, 16'h0000, 0, 0, 0},
      '{4'h5, 20'h0_0005, 16'h00AA, 0, 0, 2}, '{4'h5, 20'h0_0006, 16'h0055, 0, 0, 2},
      '{4'h6, 20'h0_0000, 16'h0000, 0, 0, 2}, '{4'h0, 20'h0_0005, 16'h0000, 1, 16'h00AA, 0},
      '{4'h7, 20'h0_0000, 16'h0000, 0, 0, 6}, '{4'h0, 20'h0_0005, 16'h0000, 1, 16'hFFFF, 0}};
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      n0 = dev_u.wr_count;
      run_op(rows[i].op, rows[i].a, rows[i].d);
      check("bus writes", rows[i].n, 32'(dev_u.wr_count - n0));
      if (rows[i].c) begin
        rd(flash_host_pkg::REG_DATA, v);
        check("read data", {16'h0000, rows[i].e}, v);
      end
    end
    run_op(4'h4, 20'h0_0000, 16'h0000);
    rd(flash_host_pkg::REG_STATUS, v);
    check("bypass flag", 32'h0000_0008, v);
    run_op(4'h6, 20'h0_0000, 16'h0000);
    // undefined op codes must not start any sequence
    n0 = dev_u.wr_count;
    run_op(4'h9, 20'h0_0000, 16'h0000);
    check("undefined op", 32'h0000_0000, 32'(dev_u.wr_count - n0));
    // timing limit during program: flag, then the reset command, then clear
    dev_u.fail_next <= 1'b1;
    run_op(4'h3, 20'h0_0007, 16'h0F0F);
    rd(flash_host_pkg::REG_STATUS, v);
    check("timeout flag", 32'h0000_0006, v);
    run_op(4'h1, 20'h0_0000, 16'h0000);
    wr(flash_host_pkg::REG_STATUS, 32'h0000_0004);
    rd(flash_host_pkg::REG_STATUS, v);
    check("timeout cleared", 32'h0000_0000, v);
    // hardware reset in the middle of an embedded program
    wr(flash_host_pkg::REG_ADDR, 32'h0000_0009);
    wr(flash_host_pkg::REG_CTRL, 32'h0000_0003);
    for (int i = 0; i < 300 && flash_ready_busy !== 1'b0; i++) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("ready after abort", 32'h0000_0001, {31'h0, flash_ready_busy});
    @(posedge clk);
    rst <= 1'b0;
    rd(flash_host_pkg::REG_STATUS, v);
    check("status after reset", 32'h0000_0000, v);
    run_op(4'h0, 20'h0_0003, 16'h0000);
    rd(flash_host_pkg::REG_DATA, v);
    check("read after abort", 32'h0000_FFFF, v);
    final_report;
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    final_report;
  end
endmodule
bind flash_host flash_host_monitor mon_u (.*);
